// *** logic/tot_regs_block.sv ***
/*
  Transmit and timeout register bank of a TCP offload engine: receive
  wait timer with sticky causes, packet length, single packet send mode,
  window update threshold and total length extension.
  Assumes the stack logic runs on the same clock and drives busy,
  current operation, remaining length, waiting phase and events.
  Assumes software keeps the timeout above its floor and the packet
  length steady while busy; the bank does not police either.
*/
`timescale 1ns/1ps

`include "tot_regs.svh"

module tot_regs_block #(
  parameter int SPACE_WIDTH = 17
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Register port
  input  wire tot_pkg::tot_reg_request_type reg_request,
  output logic [31:0]                      register_read_bus,
  // Stack status
  input  wire logic                        busy,
  input  wire logic [2:0]                  current_operation,
  input  wire logic                        send_running,
  input  wire logic [31:0]                 total_tx_length,
  input  wire logic [31:0]                 remaining_tx_length,
  // Receive wait
  input  wire logic                        wait_active,
  input  wire logic                        wait_restart,
  input  wire tot_pkg::tot_wait_phase_type wait_phase,
  input  wire tot_pkg::tot_rx_events_type  rx_events,
  output logic                             timeout_pulse,
  // Transmit settings
  output logic [15:0]                      tx_packet_length,
  output logic                             retransmit_disable,
  output logic                             push_flag_enable,
  // Window update
  input  wire logic [SPACE_WIDTH-1:0]      rx_free_space,
  input  wire logic [SPACE_WIDTH-1:0]      advertised_window,
  output logic                             window_update_request,
  // Length extension
  output logic                             length_extend,
  output logic [31:0]                      length_extend_value
);

  import tot_pkg::*;

  // ==========================================
  // Register storage

  logic [31:0] rx_wait_timeout;
  logic [31:0] timeout_cause;
  logic [15:0] packet_length;
  logic [1:0]  send_mode;
  logic [5:0]  window_update_threshold;

  logic [31:0] wait_count;
  logic [31:0] wait_limit;
  logic        wait_expired;
  logic [31:0] next_cause;
  logic [31:0] next_read;
  logic        write_hit_timeout;
  logic        write_hit_length;
  logic        write_hit_mode;
  logic        write_hit_window;
  logic        write_hit_extension;
  logic        single_packet;
  logic [SPACE_WIDTH-1:0] space_growth;
  logic [SPACE_WIDTH+5:0] threshold_bytes;

  // ==========================================
  // Write decode

  assign write_hit_timeout =
    reg_request.write_enable &&
    (reg_request.register_select == `TOT_ADDR_TIMEOUT);

  assign write_hit_length =
    reg_request.write_enable &&
    (reg_request.register_select == `TOT_ADDR_PACKET_LENGTH);

  assign write_hit_mode =
    reg_request.write_enable &&
    (reg_request.register_select == `TOT_ADDR_SEND_MODE);

  assign write_hit_window =
    reg_request.write_enable &&
    (reg_request.register_select == `TOT_ADDR_WINDOW);

  assign write_hit_extension =
    reg_request.write_enable &&
    (reg_request.register_select == `TOT_ADDR_EXTENSION);

  // ==========================================
  // Timeout value

  // Causes, not this value, read back here
  // value above floor assumed
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_wait_timeout <= `TOT_TIMEOUT_RESET;
    end else if (write_hit_timeout) begin
      rx_wait_timeout <= reg_request.write_data;
    end
  end

  // ==========================================
  // Receive wait timer

  // Zero acts like one instead of never expiring
  assign wait_limit = (rx_wait_timeout == 32'h0) ? 32'h0 :
                      (rx_wait_timeout - 32'h1);

  // count clock cycles
  // Restart in the same cycle wins over expiry
  assign wait_expired = wait_active && !wait_restart &&
                        (wait_count >= wait_limit);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_count <= 32'h0;
    end else if (!wait_active || wait_restart || wait_expired) begin
      wait_count <= 32'h0;
    end else begin
      wait_count <= wait_count + 32'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timeout_pulse <= 1'b0;
    end else begin
      timeout_pulse <= wait_expired;
    end
  end

  // ==========================================
  // Cause flags

  always_comb begin
    next_cause = timeout_cause;
    if (wait_expired) begin
      unique case (wait_phase)
        TOT_WAIT_ARP:           next_cause[`TOT_BIT_ARP] = 1'b1;
        TOT_WAIT_SYN_ACK:       next_cause[`TOT_BIT_SYN_ACK] = 1'b1;
        TOT_WAIT_PASSIVE_OPEN:  next_cause[`TOT_BIT_PASSIVE_OPEN] = 1'b1;
        TOT_WAIT_FIN_ACK:       next_cause[`TOT_BIT_FIN_ACK] = 1'b1;
        TOT_WAIT_PASSIVE_CLOSE: next_cause[`TOT_BIT_PASSIVE_CLOSE] = 1'b1;
        TOT_WAIT_DATA_ACK:      next_cause[`TOT_BIT_DATA_ACK] = 1'b1;
        TOT_WAIT_RX_DATA:       next_cause[`TOT_BIT_RX_SEQUENCE] = 1'b1;
        default:                next_cause[`TOT_BIT_RX_SEQUENCE] = 1'b1;
      endcase
    end
    // Expiry and events may land together
    // buffer full drop
    if (rx_events.rx_dropped) begin
      next_cause[`TOT_BIT_RX_DROPPED] = 1'b1;
    end
    if (rx_events.rx_loss) begin
      next_cause[`TOT_BIT_RX_LOSS] = 1'b1;
    end
    if (rx_events.rx_reset_flag) begin
      next_cause[`TOT_BIT_RX_RESET_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timeout_cause <= 32'h0;
    end else begin
      timeout_cause <= next_cause;
    end
  end

  // ==========================================
  // Packet length

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      packet_length <= `TOT_PACKET_LENGTH_RESET;
    end else if (write_hit_length) begin
      packet_length <= reg_request.write_data[15:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_packet_length <= `TOT_PACKET_LENGTH_RESET & `TOT_LENGTH_ALIGN_MASK;
    end else if (write_hit_length) begin
      tx_packet_length <= reg_request.write_data[15:0] & `TOT_LENGTH_ALIGN_MASK;
    end
  end

  // ==========================================
  // Single packet send mode

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      send_mode <= `TOT_SEND_MODE_RESET;
    end else if (write_hit_mode) begin
      send_mode <= reg_request.write_data[1:0];
    end
  end

  // only for one packet
  // Low bits of the total are ignored too
  assign single_packet =
    ({16'h0, tx_packet_length} == {total_tx_length[31:3], 3'b000});

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      retransmit_disable <= 1'b0;
      push_flag_enable   <= 1'b0;
    end else begin
      // Outputs follow mode one cycle later
      retransmit_disable <= single_packet &&
                            send_mode[`TOT_BIT_NO_RETRANSMIT];
      push_flag_enable   <= single_packet &&
                            send_mode[`TOT_BIT_PUSH_FLAG];
    end
  end

  // ==========================================
  // Window update

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      window_update_threshold <= `TOT_WINDOW_RESET;
    end else if (write_hit_window) begin
      window_update_threshold <= reg_request.write_data[5:0];
    end
  end

  assign threshold_bytes =
    {{SPACE_WIDTH{1'b0}}, window_update_threshold} << `TOT_WINDOW_UNIT_SHIFT;

  // Shrinking space never counts as growth
  assign space_growth = (rx_free_space > advertised_window) ?
                        (rx_free_space - advertised_window) :
                        {SPACE_WIDTH{1'b0}};

  // request on growth
  // Level request, stack picks the send time
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      window_update_request <= 1'b0;
    end else begin
      window_update_request <= (window_update_threshold != 6'h00) &&
        ({6'h00, space_growth} > threshold_bytes);
    end
  end

  // ==========================================
  // Total length extension

  // no overflow assumed
  // Writes outside a running send are dropped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      length_extend       <= 1'b0;
      length_extend_value <= 32'h0;
    end else begin
      length_extend <= write_hit_extension && send_running;
      if (write_hit_extension && send_running) begin
        length_extend_value <= reg_request.write_data;
      end
    end
  end

  // ==========================================
  // Read back

  always_comb begin
    next_read = 32'h0;
    unique case (reg_request.register_select)
      `TOT_ADDR_COMMAND:       next_read = {28'h0, current_operation, busy};
      `TOT_ADDR_TOTAL_LENGTH:  next_read = remaining_tx_length;
      `TOT_ADDR_TIMEOUT:       next_read = timeout_cause;
      `TOT_ADDR_PACKET_LENGTH: next_read = {16'h0, packet_length};
      `TOT_ADDR_SEND_MODE:     next_read = {30'h0, send_mode};
      `TOT_ADDR_WINDOW:        next_read = {26'h0, window_update_threshold};
      // Extension register reads as zero
      default:                 next_read = 32'h0;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      register_read_bus <= 32'h0;
    end else begin
      register_read_bus <= next_read;
    end
  end

endmodule

// *** logic/tot_regs.svh ***
/*
  Register offsets, field positions, reset values and limits of the
  transmit and timeout register bank.
  Assumes a 4-bit register select and 32-bit data.
*/
`ifndef TOT_REGS_SVH
`define TOT_REGS_SVH

// ==========================================
// Offsets
`define TOT_ADDR_COMMAND        4'h1
`define TOT_ADDR_TOTAL_LENGTH   4'h8
`define TOT_ADDR_TIMEOUT        4'h9
`define TOT_ADDR_PACKET_LENGTH  4'ha
`define TOT_ADDR_SEND_MODE      4'hb
`define TOT_ADDR_WINDOW         4'hc
`define TOT_ADDR_EXTENSION      4'hd

// ==========================================
// Cause bit positions
`define TOT_BIT_ARP             0
`define TOT_BIT_SYN_ACK         1
`define TOT_BIT_PASSIVE_OPEN    2
`define TOT_BIT_FIN_ACK         3
`define TOT_BIT_PASSIVE_CLOSE   4
`define TOT_BIT_DATA_ACK        5
`define TOT_BIT_RX_SEQUENCE     6
`define TOT_BIT_RX_DROPPED      23
`define TOT_BIT_RX_LOSS         27
`define TOT_BIT_RX_RESET_FLAG   30

// ==========================================
// Send mode fields
`define TOT_BIT_NO_RETRANSMIT   0
`define TOT_BIT_PUSH_FLAG       1

// ==========================================
// Reset values and limits
`define TOT_TIMEOUT_RESET       32'h0000_6001
`define TOT_PACKET_LENGTH_RESET 16'h05b0
`define TOT_SEND_MODE_RESET     2'h0
`define TOT_WINDOW_RESET        6'h00
`define TOT_LENGTH_ALIGN_MASK   16'hfff8
`define TOT_WINDOW_UNIT_SHIFT   10

`endif

// *** logic/tot_pkg.sv ***
/*
  Types of the transmit and timeout register bank.
  Assumes tot_regs.svh carries all numbers.
*/
package tot_pkg;

  // ==========================================
  // Waiting phase reported by the stack
  typedef enum logic [2:0] {
    TOT_WAIT_ARP,
    TOT_WAIT_SYN_ACK,
    TOT_WAIT_PASSIVE_OPEN,
    TOT_WAIT_FIN_ACK,
    TOT_WAIT_PASSIVE_CLOSE,
    TOT_WAIT_DATA_ACK,
    TOT_WAIT_RX_DATA
  } tot_wait_phase_type;

  // ==========================================
  // Register port request
  typedef struct packed {
    logic [3:0]  register_select;
    logic [31:0] write_data;
    logic        write_enable;
  } tot_reg_request_type;

  // ==========================================
  // Receive error events, one-cycle pulses
  typedef struct packed {
    logic rx_dropped;
    logic rx_loss;
    logic rx_reset_flag;
  } tot_rx_events_type;

endpackage

// *** dv/tot_host_model.sv ***
/*
  Model of the user logic that drives the register port.
  Assumes the bank takes requests on the rising clock edge.
*/
`timescale 1ns/1ps

module tot_host_model (
  // Clock
  input  wire logic                    clock,
  // Register port
  output tot_pkg::tot_reg_request_type reg_request,
  input  wire logic [31:0]             register_read_bus
);
  import tot_pkg::*;

  initial reg_request = '0;

  // ==========================================
  // Register cycles, launched at the falling edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_request = '{a, d, 1'b1};
    @(negedge clock);
    reg_request = '{a, ~d, 1'b0};
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    @(negedge clock);
    reg_request.register_select = a;
    @(posedge clock);
    #1;
    q = register_read_bus;
  endtask
endmodule

// *** dv/tot_regs_block_assertions.sv ***
/*
  Concurrent checks of the transmit and timeout register bank.
  Assumes it is bound to tot_regs_block and sees its ports only.
*/
`timescale 1ns/1ps
`include "tot_regs.svh"

module tot_regs_block_assertions #(
  parameter int SPACE_WIDTH = 17
) (
  // Clock and reset
  input wire logic                         clock,
  input wire logic                         reset,
  // Register port
  input wire tot_pkg::tot_reg_request_type reg_request,
  input wire logic [31:0]                  register_read_bus,
  // Status and events
  input wire logic                         busy,
  input wire logic [2:0]                   current_operation,
  input wire logic                         send_running,
  input wire logic [31:0]                  remaining_tx_length,
  input wire tot_pkg::tot_wait_phase_type  wait_phase,
  input wire tot_pkg::tot_rx_events_type   rx_events,
  input wire logic                         timeout_pulse,
  // Settings and window
  input wire logic [15:0]                  tx_packet_length,
  input wire logic [SPACE_WIDTH-1:0]       rx_free_space,
  input wire logic [SPACE_WIDTH-1:0]       advertised_window,
  input wire logic                         window_update_request,
  input wire logic                         length_extend,
  input wire logic [31:0]                  length_extend_value
);
  import tot_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [3:0] sel;
  logic       we;
  assign sel = reg_request.register_select;
  assign we = reg_request.write_enable;

  // ==========================================
  // Sequences
  sequence s_cause_read; sel == `TOT_ADDR_TIMEOUT ##1 sel == `TOT_ADDR_TIMEOUT; endsequence
  sequence s_event_read; rx_events != 3'h0 ##1 sel == `TOT_ADDR_TIMEOUT; endsequence

  // ==========================================
  // Properties
  property p_pulse; timeout_pulse |=> !timeout_pulse; endproperty
  property p_cause;
    timeout_pulse && sel == `TOT_ADDR_TIMEOUT |=> register_read_bus[$past(wait_phase, 2)];
  endproperty
  property p_sticky;
    s_cause_read |=> (register_read_bus & $past(register_read_bus)) == $past(register_read_bus);
  endproperty
  property p_event;
    s_event_read |=> ({register_read_bus[23], register_read_bus[27], register_read_bus[30]}
      & $past(rx_events, 2)) == $past(rx_events, 2);
  endproperty
  property p_busy;
    sel == `TOT_ADDR_COMMAND |=> register_read_bus == {28'h0, $past(current_operation), $past(busy)};
  endproperty
  property p_left; sel == `TOT_ADDR_TOTAL_LENGTH |=> register_read_bus == $past(remaining_tx_length); endproperty
  property p_length;
    we && sel == `TOT_ADDR_PACKET_LENGTH |=>
      tx_packet_length == ($past(reg_request.write_data[15:0]) & `TOT_LENGTH_ALIGN_MASK);
  endproperty
  property p_extend;
    we && sel == `TOT_ADDR_EXTENSION && send_running |=>
      length_extend && length_extend_value == $past(reg_request.write_data);
  endproperty
  property p_no_extend; length_extend |-> $past(we && sel == `TOT_ADDR_EXTENSION && send_running); endproperty
  property p_window;
    window_update_request |-> $past(rx_free_space) > $past(advertised_window) + 18'd1024;
  endproperty

  a_pulse: assert property (p_pulse) else $error("timeout pulse too long");
  a_cause: assert property (p_cause) else $error("cause bit missing");
  a_sticky: assert property (p_sticky) else $error("cause bit lost");
  a_event: assert property (p_event) else $error("event bit missing");
  a_busy: assert property (p_busy) else $error("status read wrong");
  a_left: assert property (p_left) else $error("remaining read wrong");
  a_length: assert property (p_length) else $error("packet length wrong");
  a_extend: assert property (p_extend) else $error("extension missing");
  a_no_extend: assert property (p_no_extend) else $error("stray extension");
  a_window: assert property (p_window) else $error("stray window update");
endmodule

bind tot_regs_block tot_regs_block_assertions #(.SPACE_WIDTH(SPACE_WIDTH)) chk_u (.clock, .reset,
  .reg_request, .register_read_bus, .busy, .current_operation, .send_running, .remaining_tx_length,
  .wait_phase, .rx_events, .timeout_pulse, .tx_packet_length, .rx_free_space, .advertised_window,
  .window_update_request, .length_extend, .length_extend_value);

// *** dv/tb.sv ***
/*
  Self-checking bench of the transmit and timeout register bank.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "tot_regs.svh"

module tb;
  import tot_pkg::*;
  logic clock = 1'b0, reset = 1'b1, busy = 1'b0, send_running = 1'b0, wait_active = 1'b0;
  logic [2:0] current_operation = 3'h0;
  logic wait_restart = 1'b0;
  logic [31:0] total_tx_length = 32'h0, remaining_tx_length = 32'h0, register_read_bus;
  tot_wait_phase_type wait_phase = TOT_WAIT_ARP;
  tot_rx_events_type rx_events = '0;
  tot_reg_request_type reg_request;
  logic [16:0] rx_free_space = 17'h0, advertised_window = 17'h0;
  logic timeout_pulse, retransmit_disable, push_flag_enable, window_update_request, length_extend;
  logic [15:0] tx_packet_length;
  logic [31:0] length_extend_value;
  int n_fail = 0, n_checks = 0;

  always #5 clock = ~clock;

  tot_host_model host_u (.clock(clock), .reg_request(reg_request),
    .register_read_bus(register_read_bus));
  tot_regs_block dut_u (.clock(clock), .reset(reset), .reg_request(reg_request),
    .register_read_bus(register_read_bus), .busy(busy), .current_operation(current_operation),
    .send_running(send_running), .total_tx_length(total_tx_length),
    .remaining_tx_length(remaining_tx_length), .wait_active(wait_active),
    .wait_restart(wait_restart),
    .wait_phase(wait_phase), .rx_events(rx_events), .timeout_pulse(timeout_pulse),
    .tx_packet_length(tx_packet_length), .retransmit_disable(retransmit_disable),
    .push_flag_enable(push_flag_enable), .rx_free_space(rx_free_space),
    .advertised_window(advertised_window), .window_update_request(window_update_request),
    .length_extend(length_extend), .length_extend_value(length_extend_value));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] q, exp, t;
    logic [15:0] v;
    logic [5:0]  thr;
    int          n;
    q = $urandom(32'hd427af25);
    repeat (5) @(posedge clock);
    @(negedge clock);
    reset = 1'b0;
    // ==========================================
    // Reset values and unmapped reads
    host_u.rd(`TOT_ADDR_PACKET_LENGTH, q);
    chk(q, 32'h5b0);
    host_u.rd(`TOT_ADDR_SEND_MODE, q);
    chk(q, 32'h0);
    host_u.rd(`TOT_ADDR_WINDOW, q);
    chk(q, 32'h0);
    host_u.rd(4'h0, q);
    chk(q, 32'h0);
    // ==========================================
    // Timer per phase, short waits after the first
    host_u.rd(`TOT_ADDR_TIMEOUT, q);
    chk(q, 32'h0);
    exp = 32'h0;
    for (int p = 0; p < 7; p++) begin
      t = p == 0 ? `TOT_TIMEOUT_RESET : 32'h20;
      if (p == 0) host_u.wr(`TOT_ADDR_TIMEOUT, t);
      if (p == 1) host_u.wr(`TOT_ADDR_TIMEOUT, t);
      @(negedge clock);
      wait_phase = tot_wait_phase_type'(p);
      wait_active = 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (timeout_pulse !== 1'b1 && n < int'(t) + 4);
      chk(32'(n), t);
      if (timeout_pulse !== 1'b1) test_done();
      @(negedge clock);
      wait_active = 1'b0;
      exp[p] = 1'b1;
      host_u.rd(`TOT_ADDR_TIMEOUT, q);
      chk(q, exp);
    end
    // Restart mid wait, a full period follows
    @(negedge clock);
    wait_active = 1'b1;
    repeat (10) @(negedge clock);
    wait_restart = 1'b1;
    @(negedge clock);
    wait_restart = 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (timeout_pulse !== 1'b1 && n < int'(t) + 4);
    chk(32'(n), t);
    if (timeout_pulse !== 1'b1) test_done();
    @(negedge clock);
    wait_active = 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      rx_events = 3'h4 >> i;
      @(negedge clock);
      rx_events = 3'h0;
    end
    host_u.rd(`TOT_ADDR_TIMEOUT, q);
    chk(q, exp | 32'h4880_0000);
    // ==========================================
    // Packet length, busy low throughout
    for (int i = 0; i < 6; i++) begin
      v = i == 0 ? 16'd8 : i == 1 ? 16'd16000 : i == 2 ? 16'h5b7 : 16'($urandom_range(2000, 1) * 8);
      host_u.wr(`TOT_ADDR_PACKET_LENGTH, {16'h0, v});
      host_u.rd(`TOT_ADDR_PACKET_LENGTH, q);
      chk(q, {16'h0, v});
      chk({16'h0, tx_packet_length}, {16'h0, v & `TOT_LENGTH_ALIGN_MASK});
    end
    for (int m = 0; m < 8; m++) begin
      @(negedge clock);
      total_tx_length = {16'h0, v & `TOT_LENGTH_ALIGN_MASK} + (m[2] ? 32'h0 : 32'h8);
      host_u.wr(`TOT_ADDR_SEND_MODE, 32'(m[1:0]));
      host_u.rd(`TOT_ADDR_SEND_MODE, q);
      chk(q, 32'(m[1:0]));
      chk({30'h0, push_flag_enable, retransmit_disable}, m[2] ? 32'(m[1:0]) : 32'h0);
    end
    chk({16'h0, tx_packet_length}, {16'h0, v & `TOT_LENGTH_ALIGN_MASK});
    // ==========================================
    // Window update threshold
    for (int i = 0; i < 8; i++) begin
      thr = i < 6 ? 6'(i >> 1) : 6'($urandom_range(63, 4));
      host_u.wr(`TOT_ADDR_WINDOW, {26'h0, thr});
      @(negedge clock);
      advertised_window = 17'd1000;
      rx_free_space = 17'd1000 + 17'(thr) * 17'd1024 + (i[0] ? 17'd8 : 17'd0);
      repeat (2) @(posedge clock);
      #1;
      chk({31'h0, window_update_request}, {31'h0, thr != 6'h0 && i[0]});
    end
    // ==========================================
    // Status reads and length extension
    @(negedge clock);
    busy = 1'b1;
    current_operation = 3'($urandom);
    remaining_tx_length = 32'h2_0000 + ($urandom & 32'hfff8);
    send_running = 1'b1;
    host_u.rd(`TOT_ADDR_COMMAND, q);
    chk(q, {28'h0, current_operation, 1'b1});
    host_u.rd(`TOT_ADDR_TOTAL_LENGTH, q);
    chk(q, remaining_tx_length);
    t = $urandom_range(32'h1000, 1) * 8;
    for (int i = 0; i < 2; i++) begin
      host_u.wr(`TOT_ADDR_EXTENSION, t + 32'(i * 8));
      chk({31'h0, length_extend}, 32'(1 - i));
      chk(length_extend_value, t);
      @(negedge clock);
      send_running = 1'b0;
    end
    host_u.rd(`TOT_ADDR_EXTENSION, q);
    chk(q, 32'h0);
    test_done();
  end
endmodule
